// *** design/cpe_defines.vh ***
// Constants for the command, pending-acknowledge and event engine.
`ifndef CPE_DEFINES_VH
`define CPE_DEFINES_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CPE_CLK_MHZ            100
`define CPE_CYC_PER_MS         (1000 * `CPE_CLK_MHZ)
`define CPE_MAX_RESPONSE_TIME_READ_LIMIT_MS 50
`define CPE_PEND_LEAD_MS       16'h0001
`define CPE_PKT_WINDOW_US      10000
`define CPE_PKT_WINDOW_CYC     (`CPE_PKT_WINDOW_US * `CPE_CLK_MHZ)
`define CPE_FLUSH_QUIET_US     10000
`define CPE_FLUSH_QUIET_CYC    (`CPE_FLUSH_QUIET_US * `CPE_CLK_MHZ)
`define CPE_EVT_ACK_MS         100
`define CPE_EVT_ACK_CYC        (`CPE_EVT_ACK_MS * `CPE_CYC_PER_MS)

// ----------------------------------------------------------------------
// Packet sizes
// ----------------------------------------------------------------------
`define CPE_PREFIX_BYTES       8'h04
`define CPE_HDR_BYTES          8'h08

// ----------------------------------------------------------------------
// Answer kinds and status codes
// ----------------------------------------------------------------------
`define CPE_KIND_FINAL         2'h0
`define CPE_KIND_PENDING       2'h1
`define CPE_KIND_OCCUPIED      2'h2
`define CPE_STATUS_OK          16'h0000
`define CPE_DEVICE_OCCUPIED_CODE 16'h8001

// ----------------------------------------------------------------------
// Event source tag layout, event slots and retries
// ----------------------------------------------------------------------
`define CPE_EVT_NUM_LSB        0
`define CPE_EVT_NUM_W          12
`define CPE_EVT_RSVD_LSB       12
`define CPE_EVT_NS_LSB         14
`define CPE_NS_PROTOCOL        2'h0
`define CPE_NS_TECHNOLOGY      2'h1
`define CPE_NS_DEVICE          2'h2
`define CPE_EVT_GENERIC_ERROR  12'h000
`define CPE_EVT_SLOTS          3'h4
`define CPE_EVT_RETRIES        2'h3

`endif

// *** design/cpe_ms_timer.v ***
// Millisecond down-counter that pulses once when its loaded time runs out.
`timescale 1ns/1ps
`default_nettype none
module cpe_ms_timer #(
	parameter CYC_PER_MS = 100000
) (
	input  wire        sys_clk_i,
	input  wire        nrst_i,
	input  wire        load_i,
	input  wire        stop_i,
	input  wire [15:0] ms_i,
	output wire        expired_o,
	output wire        running_o
);
	localparam [31:0] SUB_LAST = CYC_PER_MS - 1;

	reg [31:0] sub_q;
	reg [15:0] ms_q;
	reg        run_q;
	reg        exp_q;

	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sub_q <= 32'h00000000;
			ms_q  <= 16'h0000;
			run_q <= 1'b0;
			exp_q <= 1'b0;
		end
		else
		begin
			exp_q <= 1'b0;
			if (load_i)
			begin
				// A zero load would wrap to 16'hFFFF and expire far too late, so it counts as one.
				ms_q  <= (ms_i == 16'h0000) ? 16'h0001 : ms_i;
				sub_q <= 32'h00000000;
				run_q <= 1'b1;
			end
			else if (stop_i)
				run_q <= 1'b0;
			else if (run_q)
			begin
				if (sub_q == SUB_LAST)
				begin
					sub_q <= 32'h00000000;
					if (ms_q == 16'h0001)
					begin
						run_q <= 1'b0;
						exp_q <= 1'b1;
					end
					else
						ms_q <= ms_q - 16'h0001;
				end
				else
					sub_q <= sub_q + 32'h00000001;
			end
		end
	end

	assign expired_o = exp_q;
	assign running_o = run_q;
endmodule // cpe_ms_timer
`default_nettype wire

// *** design/cpe_engine.v ***
// Command receiver with pending answers, event sender and failure handling.
`timescale 1ns/1ps
`default_nettype none
`include "cpe_defines.vh"
module cpe_engine #(
	parameter CYC_PER_MS      = `CPE_CYC_PER_MS,
	parameter PKT_WINDOW_CYC  = `CPE_PKT_WINDOW_CYC,
	parameter FLUSH_QUIET_CYC = `CPE_FLUSH_QUIET_CYC,
	parameter EVT_ACK_CYC     = `CPE_EVT_ACK_CYC
) (
	input  wire        sys_clk_i,
	input  wire        nrst_i,
	input  wire        rx_valid_i,
	input  wire        rx_sop_i,
	input  wire        rx_eop_i,
	input  wire        rx_crc_ok_i,
	input  wire        rx_hdr_ok_i,
	input  wire [15:0] pkt_lane_i,
	input  wire [15:0] pkt_tag_i,
	input  wire        pkt_ack_req_i,
	input  wire        pkt_resend_i,
	input  wire        pkt_max_response_time_read_i,
	input  wire        pkt_event_reply_i,
	input  wire [15:0] default_lane_i,
	input  wire [15:0] msg_lane_i,
	input  wire        framed_i,
	input  wire        heartbeat_en_i,
	input  wire [15:0] max_response_time_i,
	input  wire [15:0] pend_ms_i,
	output wire        exec_start_o,
	output wire [15:0] exec_tag_o,
	input  wire        exec_done_i,
	input  wire [15:0] exec_status_i,
	output wire        ack_valid_o,
	input  wire        ack_ready_i,
	output wire [1:0]  ack_kind_o,
	output wire [15:0] ack_tag_o,
	output wire [15:0] ack_status_o,
	output wire [15:0] ack_value_o,
	output wire        hb_suspend_o,
	output wire        rx_err_o,
	output wire        flushing_o,
	input  wire        ev_valid_i,
	output wire        ev_ready_o,
	input  wire [11:0] ev_num_i,
	input  wire [1:0]  ev_ns_i,
	output wire        evc_valid_o,
	input  wire        evc_ready_i,
	output wire [15:0] evc_lane_o,
	output wire [15:0] evc_tag_o,
	output wire [2:0]  evc_count_o,
	output wire [63:0] evc_src_o,
	output wire        evc_fail_o
);
	// ------------------------------------------------------------------
	// Helpers and states
	// ------------------------------------------------------------------
	localparam [1:0]  RX_IDLE   = 2'h0;
	localparam [1:0]  RX_RECV   = 2'h1;
	localparam [1:0]  RX_FLUSH  = 2'h2;
	localparam [1:0]  EV_COLL   = 2'h0;
	localparam [1:0]  EV_SEND   = 2'h1;
	localparam [1:0]  EV_WAIT   = 2'h2;
	localparam [31:0] WIN_LAST  = PKT_WINDOW_CYC - 1;
	localparam [31:0] QUIET_LAST = FLUSH_QUIET_CYC - 1;
	localparam [31:0] EVW_LAST  = EVT_ACK_CYC - 1;
	localparam [7:0]  MIN_BYTES = `CPE_PREFIX_BYTES + `CPE_HDR_BYTES;
	localparam [2:0]  EV_FULL   = `CPE_EVT_SLOTS;

	// Time left before the host's deadline, less a safety lead.
	function [15:0] lead_ms;
		input [15:0] ms;
		begin
			if (ms > `CPE_PEND_LEAD_MS)
				lead_ms = ms - `CPE_PEND_LEAD_MS;
			else
				lead_ms = 16'h0001;
		end
	endfunction

	function [15:0] src_tag;
		input [1:0]  ns;
		input [11:0] num;
		begin
			src_tag = {ns, 2'b00, num};
		end
	endfunction

	// ------------------------------------------------------------------
	// Reception and failure handling
	// ------------------------------------------------------------------
	reg [1:0]  rx_st_q;
	reg [31:0] win_q;
	reg [7:0]  cnt_q;
	reg        rx_err_q;
	wire [7:0] len_now = (rx_st_q == RX_RECV) ?
		((cnt_q == 8'hFF) ? 8'hFF : cnt_q + 8'h01) : 8'h01;
	wire       eop_now = rx_valid_i && rx_eop_i &&
		((rx_st_q == RX_RECV) || (rx_st_q == RX_IDLE && rx_sop_i));
	wire       pkt_ok  = rx_crc_ok_i && rx_hdr_ok_i &&
		(len_now >= MIN_BYTES);
	wire       pkt_good = eop_now && pkt_ok;
	wire       rx_bad =
		(eop_now && !pkt_ok) ||
		(rx_st_q == RX_RECV && !eop_now && win_q == WIN_LAST) ||
		(rx_st_q == RX_RECV && rx_valid_i && rx_sop_i) ||
		(rx_st_q == RX_IDLE && rx_valid_i && !rx_sop_i);

	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rx_st_q  <= RX_IDLE;
			win_q    <= 32'h00000000;
			cnt_q    <= 8'h00;
			rx_err_q <= 1'b0;
		end
		else
		begin
			rx_err_q <= rx_bad;
			if (rx_bad)
			begin
				// Framed transports need no quiet wait after a failure.
				rx_st_q <= framed_i ? RX_IDLE : RX_FLUSH;
				win_q   <= 32'h00000000;
			end
			else
			begin
				case (rx_st_q)
				RX_IDLE:
					if (rx_valid_i && rx_sop_i && !rx_eop_i)
					begin
						rx_st_q <= RX_RECV;
						cnt_q   <= 8'h01;
						win_q   <= 32'h00000000;
					end
				RX_RECV:
					if (eop_now)
						rx_st_q <= RX_IDLE;
					else
					begin
						win_q <= win_q + 32'h00000001;
						if (rx_valid_i && cnt_q != 8'hFF)
							cnt_q <= cnt_q + 8'h01;
					end
				RX_FLUSH:
					if (rx_valid_i)
						win_q <= 32'h00000000;
					else if (win_q == QUIET_LAST)
						rx_st_q <= RX_IDLE;
					else
						win_q <= win_q + 32'h00000001;
				default:
					rx_st_q <= RX_IDLE;
				endcase
			end
		end
	end

	assign rx_err_o   = rx_err_q;
	assign flushing_o = (rx_st_q == RX_FLUSH);

	// ------------------------------------------------------------------
	// Command execution and answers
	// ------------------------------------------------------------------
	reg        exe_q;
	reg [15:0] exe_tag_q;
	reg        exe_ackreq_q;
	reg [15:0] exe_pend_q;
	reg        start_q;
	reg        pend_req_q;
	reg        fin_req_q;
	reg [15:0] fin_status_q;
	reg        last_vld_q;
	reg [15:0] last_tag_q;
	reg [15:0] last_status_q;
	reg        hb_sus_q;
	reg        ack_vld_q;
	reg [1:0]  ack_kind_q;
	reg [15:0] ack_tag_q;
	reg [15:0] ack_status_q;
	reg [15:0] ack_value_q;

	wire cmd_hit  = pkt_good && pkt_lane_i == default_lane_i &&
		!pkt_event_reply_i;
	wire slot_free = !ack_vld_q || ack_ready_i;
	wire done_now = exe_q && exec_done_i;
	wire cached   = last_vld_q && pkt_tag_i != 16'h0000 &&
		pkt_tag_i == last_tag_q;
	wire new_cmd  = cmd_hit && !exe_q && !pkt_max_response_time_read_i && !cached;
	wire pend_exp;

	// Answer selection: host command first, then completion, then timer.
	reg        ld;
	reg [1:0]  ld_kind;
	reg [15:0] ld_tag;
	reg [15:0] ld_status;
	reg [15:0] ld_value;
	reg        cmd_ans;
	reg        fin_ans;
	reg        pend_ans;
	always @*
	begin
		ld = 1'b0;
		ld_kind = `CPE_KIND_FINAL;
		ld_tag = pkt_tag_i;
		ld_status = `CPE_STATUS_OK;
		ld_value = 16'h0000;
		cmd_ans = 1'b0;
		fin_ans = 1'b0;
		pend_ans = 1'b0;
		if (cmd_hit && pkt_ack_req_i && !new_cmd)
		begin
			cmd_ans = 1'b1;
			if (exe_q && pkt_tag_i == exe_tag_q)
			begin
				ld_kind  = `CPE_KIND_PENDING;
				ld_value = exe_pend_q;
			end
			else if (exe_q)
			begin
				ld_kind   = `CPE_KIND_OCCUPIED;
				ld_status = `CPE_DEVICE_OCCUPIED_CODE;
			end
			else if (pkt_max_response_time_read_i)
				ld_value = max_response_time_i;
			else
				ld_status = last_status_q;
		end
		else if (fin_req_q)
		begin
			fin_ans   = 1'b1;
			ld_tag    = last_tag_q;
			ld_status = fin_status_q;
		end
		else if (pend_req_q && exe_q)
		begin
			pend_ans = 1'b1;
			ld_kind  = `CPE_KIND_PENDING;
			ld_tag   = exe_tag_q;
			ld_value = exe_pend_q;
		end
		ld = (cmd_ans || fin_ans || pend_ans) && slot_free;
	end

	// Any pending answer, timer-driven or a repeat for the same tag,
	// restarts the timer and holds the heartbeat off.
	wire pend_out = ld && (ld_kind == `CPE_KIND_PENDING);

	cpe_ms_timer #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_pend_timer (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.load_i    (new_cmd || pend_out),
		.stop_i    (done_now),
		.ms_i      (new_cmd ? lead_ms(max_response_time_i)
		                    : lead_ms(exe_pend_q)),
		.expired_o (pend_exp),
		.running_o ()
	);

	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			exe_q <= 1'b0;
			exe_tag_q <= 16'h0000;
			exe_ackreq_q <= 1'b0;
			exe_pend_q <= 16'h0000;
			start_q <= 1'b0;
			pend_req_q <= 1'b0;
			fin_req_q <= 1'b0;
			fin_status_q <= 16'h0000;
			last_vld_q <= 1'b0;
			last_tag_q <= 16'h0000;
			last_status_q <= 16'h0000;
			hb_sus_q <= 1'b0;
			ack_vld_q <= 1'b0;
			ack_kind_q <= `CPE_KIND_FINAL;
			ack_tag_q <= 16'h0000;
			ack_status_q <= 16'h0000;
			ack_value_q <= 16'h0000;
		end
		else
		begin
			start_q <= new_cmd;
			if (new_cmd)
			begin
				exe_q        <= 1'b1;
				exe_tag_q    <= pkt_tag_i;
				exe_ackreq_q <= pkt_ack_req_i;
				exe_pend_q   <= pend_ms_i;
			end
			if (pend_exp && exe_q && exe_ackreq_q)
				pend_req_q <= 1'b1;
			else if (pend_out)
				pend_req_q <= 1'b0;
			if (pend_out)
				hb_sus_q <= heartbeat_en_i;
			if (done_now)
			begin
				exe_q         <= 1'b0;
				pend_req_q    <= 1'b0;
				hb_sus_q      <= 1'b0;
				fin_req_q     <= exe_ackreq_q;
				fin_status_q  <= exec_status_i;
				last_vld_q    <= 1'b1;
				last_tag_q    <= exe_tag_q;
				last_status_q <= exec_status_i;
			end
			else if (ld && fin_ans)
				fin_req_q <= 1'b0;
			if (ld)
			begin
				ack_vld_q    <= 1'b1;
				ack_kind_q   <= ld_kind;
				ack_tag_q    <= ld_tag;
				ack_status_q <= ld_status;
				ack_value_q  <= ld_value;
			end
			else if (ack_ready_i)
				ack_vld_q <= 1'b0;
		end
	end

	assign exec_start_o = start_q;
	assign exec_tag_o   = exe_tag_q;
	assign ack_valid_o  = ack_vld_q;
	assign ack_kind_o   = ack_kind_q;
	assign ack_tag_o    = ack_tag_q;
	assign ack_status_o = ack_status_q;
	assign ack_value_o  = ack_value_q;
	assign hb_suspend_o = hb_sus_q;

	// ------------------------------------------------------------------
	// Event packing and message lane
	// ------------------------------------------------------------------
	reg [15:0] ev_mem [0:3];
	reg [1:0]  ev_st_q;
	reg [2:0]  ev_cnt_q;
	reg [15:0] ev_tag_q;
	reg [15:0] ev_lane_q;
	reg [31:0] ev_wait_q;
	reg [1:0]  ev_try_q;
	reg        ev_fail_q;
	wire ev_take  = ev_valid_i && ev_ready_o;
	wire lane_ok  = msg_lane_i != default_lane_i;
	wire evr_hit  = pkt_good && pkt_event_reply_i &&
		pkt_lane_i == ev_lane_q && pkt_tag_i == ev_tag_q &&
		ev_st_q == EV_WAIT;

	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ev_st_q <= EV_COLL;
			ev_cnt_q <= 3'h0;
			ev_tag_q <= 16'h0000;
			ev_lane_q <= 16'h0000;
			ev_wait_q <= 32'h00000000;
			ev_try_q <= 2'h0;
			ev_fail_q <= 1'b0;
			ev_mem[0] <= 16'h0000;
			ev_mem[1] <= 16'h0000;
			ev_mem[2] <= 16'h0000;
			ev_mem[3] <= 16'h0000;
		end
		else
		begin
			ev_fail_q <= 1'b0;
			case (ev_st_q)
			EV_COLL:
				if (ev_take)
				begin
					ev_mem[ev_cnt_q[1:0]] <= src_tag(ev_ns_i, ev_num_i);
					ev_cnt_q <= ev_cnt_q + 3'h1;
				end
				else if (ev_cnt_q != 3'h0 && lane_ok)
				begin
					ev_st_q   <= EV_SEND;
					ev_lane_q <= msg_lane_i;
					ev_try_q  <= 2'h0;
				end
			EV_SEND:
				if (evc_ready_i)
				begin
					ev_st_q   <= EV_WAIT;
					ev_wait_q <= 32'h00000000;
				end
			EV_WAIT:
				if (evr_hit || ev_wait_q == EVW_LAST)
				begin
					if (!evr_hit && ev_try_q != `CPE_EVT_RETRIES)
					begin
						ev_st_q  <= EV_SEND;
						ev_try_q <= ev_try_q + 2'h1;
					end
					else
					begin
						ev_st_q   <= EV_COLL;
						ev_cnt_q  <= 3'h0;
						ev_tag_q  <= ev_tag_q + 16'h0001;
						ev_fail_q <= !evr_hit;
					end
				end
				else
					ev_wait_q <= ev_wait_q + 32'h00000001;
			default:
				ev_st_q <= EV_COLL;
			endcase
		end
	end

	assign ev_ready_o  = (ev_st_q == EV_COLL) && (ev_cnt_q != EV_FULL);
	assign evc_valid_o = (ev_st_q == EV_SEND);
	assign evc_lane_o  = ev_lane_q;
	assign evc_tag_o   = ev_tag_q;
	assign evc_count_o = ev_cnt_q;
	assign evc_src_o   = {ev_mem[3], ev_mem[2], ev_mem[1], ev_mem[0]};
	assign evc_fail_o  = ev_fail_q;
endmodule // cpe_engine
`default_nettype wire

// *** sim/cpe_engine_properties.sv ***
// Port-level assertions for the command, pending and event engine.
`timescale 1ns/1ps
`default_nettype none
`include "cpe_defines.vh"
module cpe_engine_chk (
	input wire logic        sys_clk_i,
	input wire logic        nrst_i,
	input wire logic        rx_valid_i,
	input wire logic        rx_eop_i,
	input wire logic        rx_crc_ok_i,
	input wire logic        framed_i,
	input wire logic        heartbeat_en_i,
	input wire logic [15:0] msg_lane_i,
	input wire logic        ack_valid_o,
	input wire logic        ack_ready_i,
	input wire logic [1:0]  ack_kind_o,
	input wire logic [15:0] ack_tag_o,
	input wire logic [15:0] ack_status_o,
	input wire logic        exec_start_o,
	input wire logic        hb_suspend_o,
	input wire logic        rx_err_o,
	input wire logic        flushing_o,
	input wire logic        evc_valid_o,
	input wire logic        evc_ready_i,
	input wire logic [15:0] evc_lane_o,
	input wire logic [15:0] evc_tag_o,
	input wire logic [63:0] evc_src_o
);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	a_occupied_code:
		assert property (ack_valid_o && ack_kind_o == `CPE_KIND_OCCUPIED
		|-> ack_status_o == `CPE_DEVICE_OCCUPIED_CODE) else $error("busy code");
	a_ack_stands:
		assert property (ack_valid_o && !ack_ready_i |=> ack_valid_o &&
		$stable({ack_kind_o, ack_tag_o, ack_status_o})) else $error("ack moved");
	a_pend_suspend:
		assert property (ack_valid_o && ack_kind_o == `CPE_KIND_PENDING
		|-> ##[0:1] hb_suspend_o == heartbeat_en_i) else $error("no suspend");
	a_final_resume:
		assert property ($rose(ack_valid_o) && ack_kind_o == `CPE_KIND_FINAL
		|-> ##[0:1] !hb_suspend_o) else $error("suspend stuck");
	a_crc_silent:
		assert property (rx_valid_i && rx_eop_i && !rx_crc_ok_i && !ack_valid_o
		|=> !ack_valid_o && !exec_start_o) else $error("bad packet answered");
	a_crc_fail:
		assert property (rx_valid_i && rx_eop_i && !rx_crc_ok_i && !flushing_o
		|=> rx_err_o) else $error("bad packet not flagged");
	a_flush_start:
		assert property (rx_err_o && !framed_i |-> ##[0:1] flushing_o)
		else $error("no flush");
	a_framed_skip:
		assert property (rx_err_o && framed_i |=> !flushing_o)
		else $error("flush while framed");
	a_evt_source:
		assert property (evc_valid_o |-> evc_src_o[13:12] == 2'h0 &&
		evc_src_o[29:28] == 2'h0 && evc_src_o[45:44] == 2'h0 &&
		evc_src_o[61:60] == 2'h0 && evc_src_o[15:14] != 2'h3 &&
		evc_src_o[31:30] != 2'h3 && evc_src_o[47:46] != 2'h3 &&
		evc_src_o[63:62] != 2'h3) else $error("bad event source");
	a_evt_lane:
		assert property (evc_valid_o |-> evc_lane_o == msg_lane_i)
		else $error("event lane");
	a_evt_stands:
		assert property (evc_valid_o && !evc_ready_i |=> evc_valid_o &&
		$stable(evc_tag_o) && $stable(evc_src_o)) else $error("event moved");
	c_pending: cover property (ack_valid_o && ack_kind_o == `CPE_KIND_PENDING);
	c_busy: cover property (ack_valid_o && ack_kind_o == `CPE_KIND_OCCUPIED);
	c_event: cover property (evc_valid_o && evc_ready_i);
	c_flush: cover property ($rose(flushing_o));
endmodule // cpe_engine_chk

bind cpe_engine cpe_engine_chk u_chk (
	.sys_clk_i, .nrst_i, .rx_valid_i, .rx_eop_i, .rx_crc_ok_i, .framed_i,
	.heartbeat_en_i, .msg_lane_i, .ack_valid_o, .ack_ready_i, .ack_kind_o,
	.ack_tag_o, .ack_status_o, .exec_start_o, .hb_suspend_o, .rx_err_o,
	.flushing_o, .evc_valid_o, .evc_ready_i, .evc_lane_o, .evc_tag_o,
	.evc_src_o);
`default_nettype wire

// *** sim/cpe_host_model.sv ***
// Host model on the far side: takes answers and event commands.
`timescale 1ns/1ps
`default_nettype none
module cpe_host_model (
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	input  wire logic [3:0] slow_i,
	input  wire logic       ans_valid_i,
	input  wire logic       evc_valid_i,
	output var  logic       ans_ready_o,
	output var  logic       evc_ready_o
);
	logic [3:0] ans_cnt_q;
	logic [3:0] evc_cnt_q;

	// Both readies lag slow_i + 1 cycles, so the device must hold its offer.
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			{ans_ready_o, evc_ready_o} <= 2'h0;
			{ans_cnt_q, evc_cnt_q} <= 8'h00;
		end
		else
		begin
			ans_cnt_q <= (ans_valid_i && !ans_ready_o) ?
				ans_cnt_q + 4'h1 : 4'h0;
			ans_ready_o <= ans_valid_i && !ans_ready_o && ans_cnt_q >= slow_i;
			evc_cnt_q <= (evc_valid_i && !evc_ready_o) ?
				evc_cnt_q + 4'h1 : 4'h0;
			evc_ready_o <= evc_valid_i && !evc_ready_o && evc_cnt_q >= slow_i;
		end
	end
endmodule // cpe_host_model
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the command, pending and event engine.
`timescale 1ns/1ps
`default_nettype none
`include "cpe_defines.vh"
module tb;
	logic        sys_clk_i, nrst_i, rx_valid_i, rx_sop_i, rx_eop_i;
	logic        rx_crc_ok_i, rx_hdr_ok_i, pkt_ack_req_i, pkt_resend_i;
	logic        pkt_max_response_time_read_i, pkt_event_reply_i, framed_i, heartbeat_en_i;
	logic        exec_start_o, exec_done_i, ack_valid_o, ack_ready_i;
	logic        hb_suspend_o, rx_err_o, flushing_o, ev_valid_i, ev_ready_o;
	logic        evc_valid_o, evc_ready_i, evc_fail_o;
	logic [1:0]  ev_ns_i, ack_kind_o, ak;
	logic [2:0]  evc_count_o, ec;
	logic [3:0]  slow;
	logic [11:0] ev_num_i;
	logic [15:0] pkt_lane_i, pkt_tag_i, default_lane_i, msg_lane_i, pend_ms_i;
	logic [15:0] max_response_time_i, exec_status_i, exec_tag_o, ack_tag_o;
	logic [15:0] ack_status_o, ack_value_o, evc_lane_o, evc_tag_o;
	logic [15:0] et, at, st, va, el, eg, t0;
	logic [63:0] evc_src_o, es;
	int          errors, total_checks, starts, errs, fails, acks, evcs, lat;
	int          e0, a0, f0;
	logic [6:0]  fls [4] = '{7'h11, 7'h21, 7'h01, 7'h41};
	int          lens [4] = '{12, 12, 8, 55};

	cpe_engine #(.CYC_PER_MS(10), .PKT_WINDOW_CYC(50), .FLUSH_QUIET_CYC(20),
		.EVT_ACK_CYC(100)) uut (
		.sys_clk_i, .nrst_i, .rx_valid_i, .rx_sop_i, .rx_eop_i, .rx_crc_ok_i,
		.rx_hdr_ok_i, .pkt_lane_i, .pkt_tag_i, .pkt_ack_req_i, .pkt_resend_i,
		.pkt_max_response_time_read_i, .pkt_event_reply_i, .default_lane_i, .msg_lane_i,
		.framed_i, .heartbeat_en_i, .max_response_time_i, .pend_ms_i,
		.exec_start_o, .exec_tag_o, .exec_done_i, .exec_status_i, .ack_valid_o,
		.ack_ready_i, .ack_kind_o, .ack_tag_o, .ack_status_o, .ack_value_o,
		.hb_suspend_o, .rx_err_o, .flushing_o, .ev_valid_i, .ev_ready_o,
		.ev_num_i, .ev_ns_i, .evc_valid_o, .evc_ready_i, .evc_lane_o,
		.evc_tag_o, .evc_count_o, .evc_src_o, .evc_fail_o);
	cpe_host_model host (.sys_clk_i, .nrst_i, .slow_i(slow),
		.ans_valid_i(ack_valid_o), .evc_valid_i(evc_valid_o),
		.ans_ready_o(ack_ready_i), .evc_ready_o(evc_ready_i));

	initial
	begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// ------------------------------------------------------------------
	// Monitors and tasks
	// ------------------------------------------------------------------
	// Handshakes are taken at the edge itself, before the design updates.
	always @(posedge sys_clk_i)
	begin
		if (exec_start_o)
		begin
			starts++;
			et = exec_tag_o;
		end
		if (ack_valid_o && ack_ready_i)
		begin
			acks++;
			{ak, at, st, va} = {ack_kind_o, ack_tag_o, ack_status_o, ack_value_o};
		end
		if (evc_valid_o && evc_ready_i)
		begin
			evcs++;
			{ec, eg, el, es} = {evc_count_o, evc_tag_o, evc_lane_o, evc_src_o};
		end
		errs += int'(rx_err_o === 1'b1);
		fails += int'(evc_fail_o === 1'b1);
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic hang;
		errors++;
		$display("Error %0t: wait ran out", $time);
		summarize();
	endtask

	// Flags: 0 ack, 1 max_response_time read, 2 event reply, 3 resend, 4 bad crc,
	// 5 bad header, 6 no last byte.
	task automatic send(input logic [15:0] lane, input logic [15:0] tag,
		input logic [6:0] fl, input int len);
		pkt_lane_i = lane;
		pkt_tag_i = tag;
		{rx_hdr_ok_i, rx_crc_ok_i} = ~fl[5:4];
		{pkt_resend_i, pkt_event_reply_i, pkt_max_response_time_read_i, pkt_ack_req_i} =
			fl[3:0];
		for (int i = 0; i < len; i++)
		begin
			rx_valid_i = 1'b1;
			rx_sop_i = (i == 0);
			rx_eop_i = (i == len - 1) && !fl[6];
			@(negedge sys_clk_i);
		end
		{rx_valid_i, rx_sop_i, rx_eop_i} = 3'h0;
	endtask

	task automatic wait_for(input bit ev);
		int c;
		c = ev ? evcs : acks;
		lat = 0;
		while ((ev ? evcs : acks) == c)
		begin
			@(negedge sys_clk_i);
			lat++;
			if (lat > 600)
				hang();
		end
	endtask

	task automatic put_ev(input logic [1:0] ns, input logic [11:0] num);
		int n;
		n = 0;
		{ev_ns_i, ev_num_i, ev_valid_i} = {ns, num, 1'b1};
		while (ev_ready_o !== 1'b1)
		begin
			@(negedge sys_clk_i);
			n++;
			if (n > 300)
				hang();
		end
		@(negedge sys_clk_i);
	endtask

	initial
	begin
		nrst_i = 1'b0;
		{rx_valid_i, rx_sop_i, rx_eop_i, rx_crc_ok_i, rx_hdr_ok_i, framed_i,
			exec_done_i, ev_valid_i} = 8'h00;
		{pkt_ack_req_i, pkt_resend_i, pkt_max_response_time_read_i, pkt_event_reply_i} = 4'h0;
		{pkt_lane_i, pkt_tag_i, default_lane_i, exec_status_i} = 64'h0;
		{ev_ns_i, ev_num_i, slow} = 18'h00000;
		{heartbeat_en_i, msg_lane_i} = {1'b1, 16'h0005};
		{max_response_time_i, pend_ms_i} = {16'h0003, 16'h0008};
		repeat (2) @(negedge sys_clk_i);
		nrst_i = 1'b1;
		send(16'h0000, 16'h0001, 7'h03, 12);
		wait_for(0);
		check({ak, at, va}, {`CPE_KIND_FINAL, 16'h0001, 16'h0003});
		check(lat <= 500, 1'b1);
		slow = 4'h3;
		send(16'h0000, 16'h0002, 7'h01, 12);
		repeat (2) @(negedge sys_clk_i);
		check({starts, et}, {32'h1, 16'h0002});
		wait_for(0);
		check({ak, at, va}, {`CPE_KIND_PENDING, 16'h0002, 16'h0008});
		check(hb_suspend_o, 1'b1);
		send(16'h0000, 16'h0002, 7'h09, 12);
		wait_for(0);
		check({ak, at, va}, {`CPE_KIND_PENDING, 16'h0002, 16'h0008});
		send(16'h0000, 16'h0003, 7'h01, 12);
		wait_for(0);
		check({ak, at, st}, {`CPE_KIND_OCCUPIED, 16'h0003, 16'h8001});
		wait_for(0);
		check({ak, at, lat <= 100}, {`CPE_KIND_PENDING, 16'h0002, 1'b1});
		{exec_status_i, exec_done_i} = {16'h0042, 1'b1};
		@(negedge sys_clk_i);
		exec_done_i = 1'b0;
		wait_for(0);
		check({ak, at, st}, {`CPE_KIND_FINAL, 16'h0002, 16'h0042});
		check(hb_suspend_o, 1'b0);
		send(16'h0000, 16'h0002, 7'h09, 12);
		wait_for(0);
		check({ak, st, starts}, {`CPE_KIND_FINAL, 16'h0042, 32'h1});
		for (int i = 0; i < 4; i++)
		begin
			{e0, a0} = {errs, acks};
			send(16'h0000, 16'h0010, fls[i], lens[i]);
			repeat (3) @(negedge sys_clk_i);
			check(errs, e0 + 1);
			check(flushing_o, 1'b1);
			repeat (25) @(negedge sys_clk_i);
			check({flushing_o, acks}, {1'b0, a0});
		end
		framed_i = 1'b1;
		e0 = errs;
		send(16'h0000, 16'h0011, 7'h11, 12);
		repeat (3) @(negedge sys_clk_i);
		check({flushing_o, errs}, {1'b0, e0 + 1});
		send(16'h0000, 16'h0012, 7'h03, 12);
		wait_for(0);
		check({ak, at, va}, {`CPE_KIND_FINAL, 16'h0012, 16'h0003});
		put_ev(`CPE_NS_PROTOCOL, `CPE_EVT_GENERIC_ERROR);
		put_ev(`CPE_NS_TECHNOLOGY, 12'hABC);
		put_ev(`CPE_NS_DEVICE, 12'h123);
		ev_valid_i = 1'b0;
		wait_for(1);
		check({ec, el}, {3'h3, 16'h0005});
		check(es[47:0], 48'h8123_4ABC_0000);
		t0 = eg;
		send(16'h0005, t0, 7'h04, 12);
		repeat (3) @(negedge sys_clk_i);
		check(ev_ready_o, 1'b1);
		put_ev(`CPE_NS_DEVICE, 12'h001);
		ev_valid_i = 1'b0;
		f0 = fails;
		for (int i = 0; i < 4; i++)
		begin
			wait_for(1);
			check(eg, t0 + 16'h0001);
		end
		repeat (110) @(negedge sys_clk_i);
		check(fails, f0 + 1);
		summarize();
	end
endmodule // tb
`default_nettype wire
